// ==== core/sks_consts.svh ====
// Named constants for the skip instruction sequencer.
`ifndef SKS_CONSTS_SVH
`define SKS_CONSTS_SVH

// Slot index is 4*(n-1)+(m-1) for time slot Tn.m.
`define SKS_SLOT_W   4
`define SKS_T11      4'h0
`define SKS_T13      4'h2
`define SKS_T14      4'h3
`define SKS_T21      4'h4
`define SKS_T23      4'h6
`define SKS_T24      4'h7
`define SKS_T31      4'h8
`define SKS_T32      4'h9
`define SKS_T33      4'hA
`define SKS_T34      4'hB
`define SKS_T41      4'hC
`define SKS_T42      4'hD
`define SKS_T43      4'hE
`define SKS_T44      4'hF
`define SKS_SLOT_ONE 4'h1

// Function codes (octal 50, 56, 57) and parity sub-codes (octal 54, 55).
`define SKS_OP_W       6
`define SKS_OP_PARITY  6'h28
`define SKS_OP_CMP     6'h2E
`define SKS_OP_INC     6'h2F
`define SKS_SUB_ODD    6'h2C
`define SKS_SUB_EVEN   6'h2D

`endif

// ==== core/sks_pkg.sv ====
// Types shared by the skip instruction sequencer modules.
package sks_pkg;
    typedef enum logic [4:0] {
        SKS_IDLE = 5'h01,
        SKS_R1   = 5'h02,
        SKS_WB   = 5'h04,
        SKS_ISEQ = 5'h08,
        SKS_TAIL = 5'h10
    } sks_state_e;
endpackage

// ==== core/sks_core_if.sv ====
// Carrier between the sequencer, its slot generator and its adder.
`timescale 1ns/1ps
interface sks_core_if #(
    parameter int WIDTH = 18
);
    logic [3:0]       slot;
    logic [WIDTH-1:0] x_op;
    logic [WIDTH-1:0] d_op;
    logic             borrow_in;
    logic [WIDTH-1:0] sum;
    logic             x_eq_dn;

    modport slot_src (output slot);
    modport adder    (input x_op, input d_op, input borrow_in, output sum, output x_eq_dn);
    modport ctrl     (input slot, output x_op, output d_op, output borrow_in,
                      input sum, input x_eq_dn);
endinterface

// ==== core/sks_slot_gen.sv ====
// Free running four-phase time slot generator.
`timescale 1ns/1ps
`include "sks_consts.svh"
module sks_slot_gen (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic arst_n,
    // Slot output
    sks_core_if.slot_src core
);
    logic [3:0] slot_r;

    // One slot per clock; wraps from T4.4 back to T1.1.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slot_r <= `SKS_T11;
        end else begin
            slot_r <= slot_r + `SKS_SLOT_ONE;
        end
    end

    assign core.slot = slot_r;
endmodule

// ==== core/sks_adder.sv ====
// Subtractive adder computing X - D' with optional borrow insertion.
`timescale 1ns/1ps
module sks_adder #(
    parameter int WIDTH = 18
) (
    // Operands and result
    sks_core_if.adder core
);
    logic [WIDTH:0] wide;

    // Elaboration refuses a width too narrow for a sign and a magnitude.
    if (WIDTH < 2) begin : g_width_check
        $error("sks_adder: WIDTH too small");
    end

    // X - D' equals X + D + 1; an inserted borrow takes one away.
    always_comb begin
        wide = {1'b0, core.x_op} + {1'b0, core.d_op} + {{WIDTH{1'b0}}, 1'b1}
               - {{WIDTH{1'b0}}, core.borrow_in};
    end

    assign core.sum     = wide[WIDTH-1:0];
    assign core.x_eq_dn = (core.x_op == ~core.d_op);
endmodule

// ==== core/sks_sequencer.sv ====
// Sequencer for the increment-and-skip, parity-skip and compare-skip tail.
//
// Functional notes
// - Increment-and-skip skips the next instruction when its operand is positive zero.
// - A nonzero operand is reduced by one through the adder with borrow insertion.
// - Write-back stores the adder result into the operand's memory location.
// - Read sequence fetches the operand and places it in the second operand.
// - First operand is loaded with all ones, so comparison raises no borrow.
// - Zero operand with all-ones first operand gives an all-zero adder output.
// - Borrow insertion set at read T4.4 when unequal; cleared at write T2.3.
// - Address register cleared at prior T4.4, loaded from adder at T1.1.
// - Read T1.3 clears write data and first operand; T1.4 loads first operand.
// - Read T2.1 gates write data onward; second operand cleared T2.3, loaded T2.4.
// - Write-back starts memory T1.1, clears T1.3, loads adder at T1.4.
// - Advance subsequence runs only for a zero operand; otherwise suppressed.
// - Advance T3.3 clears operands, sets control; T3.4 copies counter, inhibits borrow.
// - Write T4.3 clears advance-control and borrow-inhibit flags.
// - Parity skips evaluate the AND of upper and lower accumulators.
// - Odd variant skips on odd parity, even variant on even parity.
// - Even count of ones is even parity, odd count is odd parity.
// - Compare-skip starts control memory only when equality flag stayed clear.
// - Compare-skip select-to-arithmetic gating drops at T3.1.
// - Parity flag set at T1.4 on odd value; counter advanced at T4.2 on skip.
`timescale 1ns/1ps
`include "sks_consts.svh"
module sks_sequencer #(
    parameter int WIDTH = 18
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // Instruction request
    input  wire logic             start,
    input  wire logic [5:0]       opcode,
    input  wire logic [5:0]       sub_code,
    input  wire logic [WIDTH-1:0] operand_addr,
    input  wire logic [WIDTH-1:0] compare_value,
    // Accumulators
    input  wire logic [WIDTH-1:0] upper_accumulator,
    input  wire logic [WIDTH-1:0] lower_accumulator,
    // Program counter preload
    input  wire logic             pc_load,
    input  wire logic [WIDTH-1:0] pc_value,
    // Memory
    input  wire logic [WIDTH-1:0] mem_rdata,
    output logic                  mem_init,
    output logic                  mem_write,
    output logic [WIDTH-1:0]      memory_address_register,
    output logic [WIDTH-1:0]      write_data_register,
    // Status
    output logic [WIDTH-1:0]      program_counter,
    output logic                  control_memory_init,
    output logic                  busy,
    output logic                  done,
    output logic                  skip_taken,
    output logic                  parity_result_flag,
    output logic                  equality_flag
);
    localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};

    sks_core_if #(.WIDTH(WIDTH)) core ();

    sks_slot_gen u_slot (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .core    (core)
    );

    sks_adder #(.WIDTH(WIDTH)) u_adder (
        .core (core)
    );

    // Elaboration refuses a width too narrow for a sign and a magnitude.
    if (WIDTH < 2) begin : g_width_check
        $error("sks_sequencer: WIDTH too small");
    end

    sks_pkg::sks_state_e state_r;
    logic [3:0]          slot;
    logic                pend_r;
    logic [5:0]          op_r;
    logic [5:0]          sub_r;
    logic [WIDTH-1:0]    x_r;
    logic [WIDTH-1:0]    d_r;
    logic [WIDTH-1:0]    arith_sel;
    logic                zsel_gate_r;
    logic                acc_gate_r;
    logic                borrow_insertion_flag;
    logic                borrow_inhibit_flag;
    logic                program_increment_flag;
    logic                advance_control_flag;
    logic                is_inc;
    logic                is_cmp;
    logic                is_par;
    logic                par_skip;
    logic                in_r1;
    logic                in_wb;
    logic                in_iseq;

    assign slot   = core.slot;
    assign is_inc = (op_r == `SKS_OP_INC);
    assign is_cmp = (op_r == `SKS_OP_CMP);
    assign is_par = (op_r == `SKS_OP_PARITY)
                    && (sub_r == `SKS_SUB_ODD || sub_r == `SKS_SUB_EVEN);
    assign in_r1   = (state_r == sks_pkg::SKS_R1);
    assign in_wb   = (state_r == sks_pkg::SKS_WB);
    assign in_iseq = (state_r == sks_pkg::SKS_ISEQ);

    // Odd variant skips on a set flag, even variant on a clear one.
    assign par_skip = (sub_r == `SKS_SUB_ODD) ? parity_result_flag
                                              : !parity_result_flag;

    // Adder operands; an inhibit holds back the inserted borrow.
    assign core.x_op      = x_r;
    assign core.d_op      = d_r;
    assign core.borrow_in = borrow_insertion_flag && !borrow_inhibit_flag;

    // Arithmetic select: accumulator AND, gated write data, or the idle level.
    // The idle level is all ones, except the compare value for compare-skip.
    always_comb begin
        if (acc_gate_r) begin
            arith_sel = upper_accumulator & lower_accumulator;
        end else if (zsel_gate_r) begin
            arith_sel = write_data_register;
        end else if (is_cmp) begin
            arith_sel = compare_value;
        end else begin
            arith_sel = ALL_ONES;
        end
    end

    // A request is held until the next sequence boundary; the set wins.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pend_r <= 1'b0;
            op_r   <= 6'h00;
            sub_r  <= 6'h00;
        end else begin
            if (start && !pend_r && !busy) begin
                pend_r <= 1'b1;
                op_r   <= opcode;
                sub_r  <= sub_code;
            end else if (slot == `SKS_T44 && state_r == sks_pkg::SKS_IDLE) begin
                pend_r <= 1'b0;
            end
        end
    end

    // Sequence changes only at T4.4, so every command keeps slot order.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= sks_pkg::SKS_IDLE;
        end else if (slot == `SKS_T44) begin
            case (state_r)
                sks_pkg::SKS_IDLE: begin
                    if (pend_r && (is_inc || is_cmp)) begin
                        state_r <= sks_pkg::SKS_R1;
                    end else if (pend_r && is_par) begin
                        state_r <= sks_pkg::SKS_ISEQ;
                    end else begin
                        state_r <= sks_pkg::SKS_IDLE;
                    end
                end
                sks_pkg::SKS_R1: begin
                    state_r <= is_inc ? sks_pkg::SKS_WB : sks_pkg::SKS_TAIL;
                end
                default: begin
                    state_r <= sks_pkg::SKS_IDLE;
                end
            endcase
        end
    end

    // Busy from acceptance until the final sequence ends.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !pend_r && !busy) begin
                busy <= 1'b1;
            end else if (slot == `SKS_T44 && busy) begin
                if (in_wb || in_iseq || (state_r == sks_pkg::SKS_TAIL)
                    || (state_r == sks_pkg::SKS_IDLE && pend_r && !is_inc && !is_cmp
                        && !is_par)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    // Address register: cleared at the prior T4.4, loaded from adder at T1.1.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            memory_address_register <= {WIDTH{1'b0}};
        end else if (slot == `SKS_T44 && state_r == sks_pkg::SKS_IDLE && pend_r
                     && (is_inc || is_cmp)) begin
            memory_address_register <= {WIDTH{1'b0}};
        end else if (slot == `SKS_T11 && in_r1) begin
            memory_address_register <= core.sum;
        end
    end

    // Memory start strobes; write-back reuses the address held from the read.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_init  <= 1'b0;
            mem_write <= 1'b0;
        end else begin
            mem_init  <= (slot == `SKS_T11) && (in_r1 || in_wb);
            mem_write <= (slot == `SKS_T11) && in_wb;
        end
    end

    // Write data register: memory path in the read, adder path in write-back.
    // The memory path is inhibited in write-back so the result is not lost.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            write_data_register <= {WIDTH{1'b0}};
        end else if (slot == `SKS_T13 && (in_r1 || in_wb)) begin
            write_data_register <= {WIDTH{1'b0}};
        end else if (slot == `SKS_T14 && in_r1) begin
            write_data_register <= mem_rdata;
        end else if (slot == `SKS_T14 && in_wb) begin
            write_data_register <= core.sum;
        end
    end

    // Path gates for the operand transfer and for the accumulator AND.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            zsel_gate_r <= 1'b0;
            acc_gate_r  <= 1'b0;
        end else begin
            if (slot == `SKS_T21 && in_r1) begin
                zsel_gate_r <= 1'b1;
            end else if (slot == `SKS_T31) begin
                zsel_gate_r <= 1'b0;
            end
            if (slot == `SKS_T11 && in_iseq) begin
                acc_gate_r <= 1'b1;
            end else if (slot == `SKS_T21) begin
                acc_gate_r <= 1'b0;
            end
        end
    end

    // First operand register.
    // At launch it holds all ones with the address in D, so the adder
    // hands the address to the address register at T1.1.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            x_r <= {WIDTH{1'b0}};
        end else if (slot == `SKS_T44 && state_r == sks_pkg::SKS_IDLE && pend_r) begin
            x_r <= ALL_ONES;
        end else if (slot == `SKS_T13 && in_r1) begin
            x_r <= {WIDTH{1'b0}};
        end else if (slot == `SKS_T14 && in_r1) begin
            x_r <= arith_sel;
        end else if (slot == `SKS_T33 && advance_go()) begin
            x_r <= {WIDTH{1'b0}};
        end
    end

    // Second operand register.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            d_r <= {WIDTH{1'b0}};
        end else if (slot == `SKS_T44 && state_r == sks_pkg::SKS_IDLE && pend_r) begin
            d_r <= operand_addr;
        end else if (slot == `SKS_T23 && in_r1) begin
            d_r <= {WIDTH{1'b0}};
        end else if (slot == `SKS_T24 && in_r1) begin
            d_r <= arith_sel;
        end else if (slot == `SKS_T33 && advance_go()) begin
            d_r <= {WIDTH{1'b0}};
        end else if (slot == `SKS_T34 && advance_control_flag) begin
            d_r <= program_counter;
        end
    end

    // The advance subsequence is entered only on a satisfied skip condition.
    function automatic logic advance_go();
        advance_go = (in_wb && program_increment_flag) || (in_iseq && par_skip);
    endfunction

    // Borrow insertion: set on a nonzero operand, cleared in write-back.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            borrow_insertion_flag <= 1'b0;
        end else if (slot == `SKS_T44 && in_r1 && is_inc && !core.x_eq_dn) begin
            borrow_insertion_flag <= 1'b1;
        end else if (slot == `SKS_T23 && in_wb) begin
            borrow_insertion_flag <= 1'b0;
        end
    end

    // Program-increment flag opens the advance only for a zero operand.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            program_increment_flag <= 1'b0;
        end else if (slot == `SKS_T31 && in_wb && core.x_eq_dn) begin
            program_increment_flag <= 1'b1;
        end else if (slot == `SKS_T41) begin
            program_increment_flag <= 1'b0;
        end
    end

    // Advance-control and borrow-inhibit flags bracket the counter step.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            advance_control_flag <= 1'b0;
            borrow_inhibit_flag  <= 1'b0;
        end else begin
            if (slot == `SKS_T33 && advance_go()) begin
                advance_control_flag <= 1'b1;
            end else if (slot == `SKS_T43) begin
                advance_control_flag <= 1'b0;
            end
            if (slot == `SKS_T34 && advance_control_flag) begin
                borrow_inhibit_flag <= 1'b1;
            end else if (slot == `SKS_T43) begin
                borrow_inhibit_flag <= 1'b0;
            end
        end
    end

    // Program counter: external preload, or the incremented adder result.
    // The internal step wins so a skip is never lost to a late preload.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            program_counter <= {WIDTH{1'b0}};
        end else if (slot == `SKS_T42 && advance_control_flag) begin
            program_counter <= core.sum;
        end else if (pc_load) begin
            program_counter <= pc_value;
        end
    end

    // Skip indication, raised for the cycle after the counter steps.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            skip_taken <= 1'b0;
        end else begin
            skip_taken <= (slot == `SKS_T42) && advance_control_flag;
        end
    end

    // Parity flag: reduction XOR is one for an odd count of ones.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            parity_result_flag <= 1'b0;
        end else if (slot == `SKS_T13 && in_iseq) begin
            parity_result_flag <= 1'b0;
        end else if (slot == `SKS_T14 && in_iseq) begin
            parity_result_flag <= ^arith_sel;
        end
    end

    // Equality flag for compare-skip, sampled at read T3.2.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            equality_flag <= 1'b0;
        end else if (slot == `SKS_T11 && in_r1 && is_cmp) begin
            equality_flag <= 1'b0;
        end else if (slot == `SKS_T32 && in_r1 && is_cmp && core.x_eq_dn) begin
            equality_flag <= 1'b1;
        end
    end

    // Control memory starts at the next T1.1 only if operands differed.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            control_memory_init <= 1'b0;
        end else begin
            control_memory_init <= (slot == `SKS_T11)
                                   && (state_r == sks_pkg::SKS_TAIL)
                                   && !equality_flag;
        end
    end
endmodule

// ==== bench/sks_mem_model.sv ====
// Behavioural main memory answering the sequencer's read and write cycles.
`timescale 1ns/1ps
module sks_mem_model (
    // Clock
    input  wire logic        clk_sys,
    // Memory requests
    input  wire logic        mem_init,
    input  wire logic        mem_write,
    input  wire logic [17:0] memory_address_register,
    input  wire logic [17:0] write_data_register,
    // Read data
    output logic      [17:0] mem_rdata
);
    logic [17:0] mem_q [logic [17:0]];
    logic [17:0] rd_q = 18'h00000;
    logic [17:0] wa_q = 18'h00000;
    int          rc_q = 0;
    int          wc_q = 0;

    // Read data is held a few cycles only, then inverted so a late sample never matches.
    assign mem_rdata = (rc_q != 0) ? rd_q : ~rd_q;

    // Write data is taken one edge after the load slot, once the register has settled.
    always @(posedge clk_sys) begin
        if (mem_init && !mem_write) begin
            rd_q <= mem_q.exists(memory_address_register) ?
                    mem_q[memory_address_register] : 18'h15555;
            rc_q <= 4;
        end else if (rc_q != 0) begin
            rc_q <= rc_q - 1;
        end
        if (mem_write) begin
            wa_q <= memory_address_register;
            wc_q <= 4;
        end else if (wc_q != 0) begin
            wc_q <= wc_q - 1;
            if (wc_q == 2) mem_q[wa_q] = write_data_register;
        end
    end
endmodule

// ==== bench/sks_checker.sv ====
// Concurrent checks on the skip sequencer's top ports.
`timescale 1ns/1ps
module sks_checker #(
    parameter int WIDTH = 18
) (
    // Clock and reset
    input wire logic             clk_sys,
    input wire logic             arst_n,
    // Memory side
    input wire logic             mem_init,
    input wire logic             mem_write,
    input wire logic [WIDTH-1:0] write_data_register,
    // Status
    input wire logic [WIDTH-1:0] program_counter,
    input wire logic             control_memory_init,
    input wire logic             busy,
    input wire logic             done,
    input wire logic             skip_taken,
    input wire logic             equality_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // The skip pulse rises on the same edge as the counter step.
    a_write_pairs: assert property (mem_write |-> mem_init)
        else $error("write pulse without memory start");
    a_skip_steps_pc: assert property (skip_taken |->
        (program_counter == WIDTH'($past(program_counter) + 1'b1)))
        else $error("skip without counter step");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_done_after_busy: assert property (done |-> $past(busy))
        else $error("done without busy");
    a_cm_if_unequal: assert property (control_memory_init |-> !equality_flag)
        else $error("control memory started on equal operands");
    a_mem_init_pulse: assert property (mem_init |=> !mem_init)
        else $error("memory start longer than one cycle");
    a_skip_then_done: assert property (skip_taken |-> ##[1:4] done)
        else $error("advance not ending the sequence");
    a_wdata_holds: assert property (mem_write |-> ##4 ($stable(write_data_register))[*8])
        else $error("write data moved after its load slot");
    a_write_to_done: assert property (mem_write |-> ##[12:18] done)
        else $error("write-back not one slot round");

    // Main scenarios reached.
    c_skip: cover property (skip_taken);
    c_cm_init: cover property (control_memory_init);
    c_write: cover property (mem_write);
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the skip instruction sequencer.
`timescale 1ns/1ps
`include "sks_consts.svh"
module tb;
    logic        clk_sys, arst_n, start, pc_load, mem_init, mem_write;
    logic        control_memory_init, busy, done, skip_taken;
    logic        parity_result_flag, equality_flag;
    logic [5:0]  opcode, sub_code;
    logic [17:0] operand_addr, compare_value, upper_accumulator, lower_accumulator;
    logic [17:0] pc_value, mem_rdata, memory_address_register;
    logic [17:0] write_data_register, program_counter, exp_pc;
    logic        skip_seen, cmi_seen;
    int          mismatches = 0;
    int          check_count = 0;

    sks_sequencer dut (.clk_sys, .arst_n, .start, .opcode, .sub_code, .operand_addr,
        .compare_value, .upper_accumulator, .lower_accumulator, .pc_load, .pc_value,
        .mem_rdata, .mem_init, .mem_write, .memory_address_register, .write_data_register,
        .program_counter, .control_memory_init, .busy, .done, .skip_taken,
        .parity_result_flag, .equality_flag);
    sks_mem_model mem (.clk_sys, .mem_init, .mem_write, .memory_address_register,
        .write_data_register, .mem_rdata);

    // Free running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // One instruction; the wait is bounded so a stuck sequencer ends the run.
    task automatic run_op(input logic [5:0] op, input logic [5:0] sub, input logic [17:0] adr);
        int n;
        opcode <= op;
        sub_code <= sub;
        operand_addr <= adr;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        skip_seen = 1'b0;
        cmi_seen = 1'b0;
        for (n = 0; n < 80; n++) begin
            @(posedge clk_sys);
            #1;
            if (skip_taken === 1'b1) skip_seen = 1'b1;
            if (control_memory_init === 1'b1) cmi_seen = 1'b1;
            if (done === 1'b1) break;
        end
        if (n == 80) begin
            mismatches++;
            end_sim();
        end
        @(posedge clk_sys);
    endtask

    // Zero, one, two and negative zero operands for increment-and-skip.
    task automatic t_inc();
        logic [17:0] ys [4] = '{18'h00000, 18'h00001, 18'h00002, 18'h3FFFF};
        logic [17:0] adr;
        logic [17:0] wb;
        foreach (ys[i]) begin
            adr = 18'h00040 + 18'(i);
            wb = (ys[i] == 0) ? 18'h0 : ys[i] - 1'b1;
            mem.mem_q[adr] = ys[i];
            run_op(`SKS_OP_INC, 6'h00, adr);
            check("write back", mem.mem_q[adr], wb);
            check("write data", write_data_register, wb);
            check("address", memory_address_register, adr);
            check("inc skip", skip_seen, ys[i] == 0);
            exp_pc = exp_pc + (ys[i] == 0);
            check("inc pc", program_counter, exp_pc);
        end
        $display("increment skip test finished");
    endtask

    // Both parity variants on odd and even words; bit 16 is masked off by the AND.
    task automatic t_parity();
        logic [5:0]  subs [2] = '{`SKS_SUB_ODD, `SKS_SUB_EVEN};
        logic [17:0] lows [2] = '{18'h00007, 18'h10003};
        logic        odd, sk;
        upper_accumulator <= 18'h2AAAF;
        foreach (subs[s]) foreach (lows[l]) begin
            lower_accumulator <= lows[l];
            odd = ^(18'h2AAAF & lows[l]);
            sk = (subs[s] == `SKS_SUB_ODD) ? odd : !odd;
            run_op(`SKS_OP_PARITY, subs[s], 18'h00000);
            check("parity flag", parity_result_flag, odd);
            check("parity skip", skip_seen, sk);
            exp_pc = exp_pc + sk;
            check("parity pc", program_counter, exp_pc);
        end
        $display("parity skip test finished");
    endtask

    // Equal and unequal operands, then an opcode the block does not know.
    task automatic t_cmp();
        int eqs = 0;
        compare_value <= 18'h12345;
        mem.mem_q[18'h00050] = 18'h12345;
        mem.mem_q[18'h00051] = 18'h2DCBA;
        for (int k = 0; k < 2; k++) begin
            run_op(`SKS_OP_CMP, 6'h00, 18'h00050 + 18'(k));
            check("equal flag", equality_flag, k == 1);
            check("control memory", cmi_seen, k == 0);
            eqs += (equality_flag === 1'b1);
        end
        check("one equal", 18'(eqs), 18'h00001);
        run_op(6'h00, 6'h00, 18'h00000);
        check("unknown skip", skip_seen, 1'b0);
        $display("compare skip test finished");
    endtask

    // Reset, preload the counter, then run every scenario.
    initial begin
        arst_n = 1'b0;
        start = 1'b0;
        pc_load = 1'b0;
        opcode = 6'h00;
        sub_code = 6'h00;
        operand_addr = 18'h00000;
        compare_value = 18'h00000;
        upper_accumulator = 18'h00000;
        lower_accumulator = 18'h00000;
        pc_value = 18'h00000;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        pc_value <= 18'h00100;
        pc_load <= 1'b1;
        @(posedge clk_sys);
        pc_load <= 1'b0;
        exp_pc = 18'h00100;
        @(posedge clk_sys);
        t_inc();
        t_parity();
        t_cmp();
        end_sim();
    end
endmodule

bind sks_sequencer sks_checker #(.WIDTH(WIDTH)) chk (.clk_sys, .arst_n, .mem_init, .mem_write,
    .write_data_register, .program_counter, .control_memory_init, .busy, .done,
    .skip_taken, .equality_flag);
